/* logic/tws_consts.svh */
// constants of the two-wire serial converter loader
// assumes inclusion by bare name from any file that needs a figure
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// ----------------------------------------------------------------------------
// word and counter layout
// ----------------------------------------------------------------------------
`define TWS_WORD_BITS     12
`define TWS_ADDR_BITS     1
`define TWS_CNT_BITS      4
`define TWS_CNT_STROBE    4'hc
`define TWS_CNT_PRELOAD   4'h0
`define TWS_ZERO_SCALE    12'h000
`define TWS_FIFO_DEPTH    8

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define TWS_CLOCK_NS      50
`define TWS_POR_MS        10
`define TWS_POR_CYCLES    ((`TWS_POR_MS * 1000000 + `TWS_CLOCK_NS - 1) / `TWS_CLOCK_NS)
`define TWS_HALF_CYCLES   4

`endif

/* logic/tws_pkg.sv */
// types of the controller end of the two-wire serial converter loader
// assumes nothing beyond a SystemVerilog compiler
package tws_pkg;

    // controller sequencing states
    typedef enum logic [2:0] {
        ST_POR,
        ST_IDLE,
        ST_SETUP,
        ST_SHIFT,
        ST_HOLD
    } tws_host_state_t;

endpackage

/* logic/tws_link_if.sv */
// link between the controller end and the converter end
// assumes the controller makes every signal; the converters only listen
`timescale 1ns/1ps
interface tws_link_if #(
    parameter int NUM_CONV = 2
);
    logic                linkClk;      // serial clock, idles high
    logic                serialDataIn; // shared serial data
    logic                loadStrobeN;  // load strobe, active low
    logic                clearN;       // shared clear, active low
    logic [NUM_CONV-1:0] chipSelN;     // per-converter select, active low

    modport host (
        output linkClk,
        output serialDataIn,
        output loadStrobeN,
        output clearN,
        output chipSelN
    );

    modport device (
        input linkClk,
        input serialDataIn,
        input loadStrobeN,
        input clearN,
        input chipSelN
    );
endinterface

/* logic/tws_fifo.sv */
// word buffer with valid/ready on both sides
// assumes both sides run on clock; no crossing inside
`timescale 1ns/1ps
module tws_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wrPtr;
        logic [PW-1:0]               rdPtr;
        logic [CW-1:0]               count;
    } tws_fifo_state_t;

    tws_fifo_state_t s_q;
    tws_fifo_state_t s_d;
    logic            push;
    logic            pop;

    // ------------------------------------------------------------------------
    // handshake and next state
    // ------------------------------------------------------------------------
    // full and empty come straight from the occupancy count
    assign inReady  = (s_q.count != CW'(DEPTH));
    assign outValid = (s_q.count != '0);
    assign outData  = s_q.mem[s_q.rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // pointers wrap at the depth, count follows push and pop
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wrPtr] = inData;
            s_d.wrPtr = (s_q.wrPtr == PW'(DEPTH - 1)) ? '0 : s_q.wrPtr + 1'b1;
        end
        if (pop) begin
            s_d.rdPtr = (s_q.rdPtr == PW'(DEPTH - 1)) ? '0 : s_q.rdPtr + 1'b1;
        end
        if (push && !pop) begin
            s_d.count = s_q.count + 1'b1;
        end else if (pop && !push) begin
            s_d.count = s_q.count - 1'b1;
        end
    end

    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

/* logic/tws_converter_end.sv */
// converter end: shared serial input register and one output register
// per converter
// assumes the link arrives from another domain and is sampled on clock
`timescale 1ns/1ps
`include "tws_consts.svh"
module tws_converter_end #(
    parameter int NUM_CONV  = 2,
    parameter int WORD_BITS = `TWS_WORD_BITS
) (
    input  wire logic                                clock,
    input  wire logic                                rst_n,
    tws_link_if.device                               link,
    output logic      [NUM_CONV-1:0][WORD_BITS-1:0]  outCode,
    output logic      [NUM_CONV-1:0]                 loadDone
);
    typedef struct packed {
        logic                               clkMeta;
        logic                               clkSync;
        logic                               clkPrev;
        logic                               dataMeta;
        logic                               dataSync;
        logic                               stbMeta;
        logic                               stbSync;
        logic                               stbPrev;
        logic [NUM_CONV-1:0]                csMeta;
        logic [NUM_CONV-1:0]                csSync;
        logic [WORD_BITS-1:0]               shiftReg;
        logic [NUM_CONV-1:0][WORD_BITS-1:0] outReg;
        logic [NUM_CONV-1:0]                done;
    } tws_dev_state_t;

    tws_dev_state_t s_q;
    tws_dev_state_t s_d;
    logic           arstN;
    logic           clkFall;
    logic           stbFall;

    // ------------------------------------------------------------------------
    // clear and edge detection
    // ------------------------------------------------------------------------
    // the shared clear acts without the clock, like the power-on reset
    assign arstN   = rst_n & link.clearN; // R07 R13
    // the converter clocks on the inverted link clock, i.e. link falling edge
    assign clkFall = s_q.clkPrev & ~s_q.clkSync; // R02
    assign stbFall = s_q.stbPrev & ~s_q.stbSync;
    assign outCode  = s_q.outReg;
    assign loadDone = s_q.done;

    // synchronisers, shifting and transfer to the output registers
    always_comb begin
        s_d          = s_q;
        s_d.clkMeta  = link.linkClk;
        s_d.clkSync  = s_q.clkMeta;
        s_d.clkPrev  = s_q.clkSync;
        s_d.dataMeta = link.serialDataIn;
        s_d.dataSync = s_q.dataMeta;
        s_d.stbMeta  = link.loadStrobeN;
        s_d.stbSync  = s_q.stbMeta;
        s_d.stbPrev  = s_q.stbSync;
        s_d.csMeta   = link.chipSelN;
        s_d.csSync   = s_q.csMeta;
        s_d.done     = '0;
        // shifting is held off while the strobe is low
        if (clkFall && s_q.stbSync) begin
            s_d.shiftReg = {s_q.shiftReg[WORD_BITS-2:0], s_q.dataSync}; // R14
        end
        // every converter saw the same bits; only selected ones take them
        for (int i = 0; i < NUM_CONV; i++) begin
            if (stbFall && !s_q.csSync[i]) begin // R09
                s_d.outReg[i] = s_q.shiftReg; // R12
                s_d.done[i]   = 1'b1;
            end
        end
    end

    // state register; clear forces zero scale into every output
    always_ff @(posedge clock or negedge arstN) begin
        if (!arstN) begin
            s_q          <= '0;
            s_q.clkMeta  <= 1'b1;
            s_q.clkSync  <= 1'b1;
            s_q.clkPrev  <= 1'b1;
            s_q.stbMeta  <= 1'b1;
            s_q.stbSync  <= 1'b1;
            s_q.stbPrev  <= 1'b1;
            s_q.csMeta   <= '1;
            s_q.csSync   <= '1;
            s_q.outReg   <= {NUM_CONV{`TWS_ZERO_SCALE}}; // R11 R13
        end else begin
            s_q <= s_d;
        end
    end
endmodule

/* logic/tws_controller_end.sv */
// controller end of the two-wire serial converter loader: word buffer,
// link clock divider, bit counter with load strobe, power-on clear and
// chip-select decoding
// assumes the converters sample the link on their own clock
//
// Operation
// R01: bit counter advances on each link rising edge
// R02: converter shifts on inverted link clock edge
// R03: count 1011 then 1100 drives strobe low
// R04: strobe preloads counter, blocks thirteenth shift
// R05: repeat thirteen pulses for every further word
// R06: clock stops high after final thirteenth pulse
// R07: one clear resets counter and converters
// R08: isolated mode holds every select low
// R09: all see data, selected converter loads
// R10: decoder enabled only after address settles
// R11: clear forces zero scale on outputs
// R12: strobe copies shift register to output
// R13: clear acts asynchronously on output register
// R14: shift register keeps latest twelve bits
// R15: counter preload value is zero
`timescale 1ns/1ps
`include "tws_consts.svh"
module tws_controller_end #(
    parameter int ADDR_W      = `TWS_ADDR_BITS,
    parameter int WORD_BITS   = `TWS_WORD_BITS,
    parameter int FIFO_DEPTH  = `TWS_FIFO_DEPTH,
    parameter int POR_CYCLES  = `TWS_POR_CYCLES,
    parameter int HALF_CYCLES = `TWS_HALF_CYCLES
) (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 wordValid,
    output logic                      wordReady,
    input  wire logic [WORD_BITS-1:0] wordData,
    input  wire logic [ADDR_W-1:0]    limitConverterSelect,
    input  wire logic                 isolatedMode,
    tws_link_if.host                  link,
    output logic                      busy
);
    localparam int NUM_CONV = 2 ** ADDR_W;
    localparam int PCW      = $clog2(POR_CYCLES + 1);
    localparam int HCW      = $clog2(HALF_CYCLES + 1);
    localparam int FW       = ADDR_W + WORD_BITS;

    typedef struct packed {
        tws_pkg::tws_host_state_t st;
        logic [PCW-1:0]           porCnt;
        logic [HCW-1:0]           halfCnt;
        logic                     linkClk;
        logic [`TWS_CNT_BITS-1:0] bitCnt;
        logic [WORD_BITS-1:0]     shiftReg;
        logic [ADDR_W-1:0]        addr;
        logic                     decEn;
        logic                     strobeN;
        logic                     clearN;
        logic                     dataOut;
        logic [NUM_CONV-1:0]      csN;
    } tws_host_state_struct_t;

    tws_host_state_struct_t s_q;
    tws_host_state_struct_t s_d;
    logic                   fifoValid;
    logic                   fifoTake;
    logic [FW-1:0]          fifoData;
    logic                   halfDone;
    logic [`TWS_CNT_BITS-1:0] cntNext;

    // ------------------------------------------------------------------------
    // word buffer
    // ------------------------------------------------------------------------
    // words wait here with their converter address; a full buffer stalls
    // the user through wordReady
    tws_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .rst_n    (rst_n),
        .inValid  (wordValid),
        .inReady  (wordReady),
        .inData   ({limitConverterSelect, wordData}),
        .outValid (fifoValid),
        .outReady (fifoTake),
        .outData  (fifoData)
    );

    // a word is taken only when the link is idle and out of clear
    // words pushed during the power-on clear simply wait in the buffer
    assign fifoTake = (s_q.st == tws_pkg::ST_IDLE);

    // ------------------------------------------------------------------------
    // link outputs
    // ------------------------------------------------------------------------
    // every link signal comes straight from a flip-flop
    assign link.linkClk      = s_q.linkClk;
    assign link.serialDataIn = s_q.dataOut;
    assign link.loadStrobeN  = s_q.strobeN;
    assign link.clearN       = s_q.clearN; // R07
    assign link.chipSelN     = s_q.csN;
    assign busy              = (s_q.st != tws_pkg::ST_IDLE) || fifoValid;

    // ------------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------------
    // the half-period divider makes the link clock from the system clock
    // each level lasts HALF_CYCLES clocks, which sets the link period
    assign halfDone = (s_q.halfCnt == HCW'(HALF_CYCLES - 1));
    assign cntNext  = s_q.bitCnt + 1'b1;

    // power-on clear, then thirteen link pulses per word
    always_comb begin
        s_d = s_q;
        unique case (s_q.st)
            tws_pkg::ST_POR: begin
                // hold the shared clear until the supply has settled
                // the counter sits at its preload value through the clear, so
                // the first word after power-on counts from zero as well
                s_d.clearN = 1'b0;
                s_d.bitCnt = `TWS_CNT_PRELOAD; // R07
                if (s_q.porCnt == PCW'(POR_CYCLES - 1)) begin
                    s_d.clearN = 1'b1;
                    s_d.st     = tws_pkg::ST_IDLE;
                end else begin
                    s_d.porCnt = s_q.porCnt + 1'b1;
                end
            end
            tws_pkg::ST_IDLE: begin
                // clock parked high, counter back at zero
                s_d.linkClk = 1'b1; // R06
                s_d.bitCnt  = `TWS_CNT_PRELOAD; // R06
                s_d.decEn   = 1'b0;
                s_d.halfCnt = '0;
                if (fifoValid) begin
                    // address is set with the decoder still off
                    s_d.shiftReg = fifoData[WORD_BITS-1:0];
                    s_d.addr     = fifoData[FW-1:WORD_BITS];
                    s_d.dataOut  = fifoData[WORD_BITS-1];
                    s_d.st       = tws_pkg::ST_SETUP;
                end
            end
            tws_pkg::ST_SETUP: begin
                // wait a half period for the address to settle
                s_d.halfCnt = s_q.halfCnt + 1'b1;
                if (halfDone) begin
                    s_d.halfCnt = '0;
                    s_d.decEn   = 1'b1; // R10
                    s_d.st      = tws_pkg::ST_SHIFT;
                end
            end
            tws_pkg::ST_SHIFT: begin
                s_d.halfCnt = s_q.halfCnt + 1'b1;
                if (halfDone) begin
                    s_d.halfCnt = '0;
                    s_d.linkClk = ~s_q.linkClk;
                    // a high clock going low is the converter's shift edge,
                    // so data only changes on the rising edge
                    if (!s_q.linkClk) begin
                        if (!s_q.strobeN) begin
                            // thirteenth rise: preload instead of count
                            s_d.bitCnt  = `TWS_CNT_PRELOAD; // R04 R15
                            s_d.strobeN = 1'b1;
                            s_d.st      = tws_pkg::ST_HOLD;
                        end else begin
                            s_d.bitCnt  = cntNext; // R01
                            // 1011 turning 1100 pulls the strobe low
                            s_d.strobeN = (cntNext != `TWS_CNT_STROBE); // R03
                            s_d.shiftReg = {s_q.shiftReg[WORD_BITS-2:0], 1'b0};
                            s_d.dataOut  = s_q.shiftReg[WORD_BITS-2];
                        end
                    end
                end
            end
            tws_pkg::ST_HOLD: begin
                // clock stays high; next word repeats the whole sequence
                // the decoder goes off here, before the next address is set up
                s_d.halfCnt = s_q.halfCnt + 1'b1;
                if (halfDone) begin
                    s_d.halfCnt = '0;
                    s_d.decEn   = 1'b0; // R10
                    s_d.st      = tws_pkg::ST_IDLE; // R05 R06
                end
            end
        endcase
        // chip selects: all low when isolated, else decoded address
        // selects follow the next state, so they leave on a flip-flop and
        // no decoder glitch reaches the link
        for (int i = 0; i < NUM_CONV; i++) begin
            if (isolatedMode) begin
                s_d.csN[i] = 1'b0; // R08
            end else begin
                s_d.csN[i] = !(s_d.decEn && (s_d.addr == ADDR_W'(i))); // R09
            end
        end
    end

    // state register; reset starts the power-on clear
    // the link parks with clock and strobe high and no converter selected
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q         <= '0;
            s_q.st      <= tws_pkg::ST_POR;
            s_q.linkClk <= 1'b1;
            s_q.strobeN <= 1'b1;
            s_q.csN     <= '1;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

/* verification/tws_link_sva.sv */
// checker of the link between the controller end and the converter end
// assumes instantiation beside the link interface, all signals on one clock
`timescale 1ns/1ps
module tws_link_sva #(
    parameter int NUM_CONV   = 2,
    parameter int POR_CYCLES = 10
) (
    input wire logic                clock,
    input wire logic                rst_n,
    input wire logic                linkClk,
    input wire logic                serialDataIn,
    input wire logic                loadStrobeN,
    input wire logic                clearN,
    input wire logic [NUM_CONV-1:0] chipSelN
);
    // ------------------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------------------
    int   riseCnt;
    int   porCnt;
    logic linkPrev;
    logic rising;

    // rising edge of the link clock seen in this cycle
    assign rising = linkClk && !linkPrev;

    // link rises since the last strobe release, and cycles spent in clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            riseCnt  <= 0;
            porCnt   <= 0;
            linkPrev <= 1'b1;
        end else begin
            linkPrev <= linkClk;
            if (!clearN) begin
                porCnt <= porCnt + 1;
            end
            if (!clearN || $rose(loadStrobeN)) begin
                riseCnt <= 0;
            end else if (rising) begin
                riseCnt <= riseCnt + 1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_strobe_count;
        $fell(loadStrobeN) |-> (riseCnt + int'(rising)) == 12;
    endproperty
    a_strobe_count: assert property (p_strobe_count)
        else $error("load strobe not at twelfth link rise");

    property p_strobe_width;
        $fell(loadStrobeN) |-> (!loadStrobeN)[*7] ##[1:2] loadStrobeN;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("load strobe width not one link period");

    property p_max_rises;
        riseCnt <= 13;
    endproperty
    a_max_rises: assert property (p_max_rises)
        else $error("more than thirteen link pulses in a word");

    property p_hold_high;
        $rose(loadStrobeN) |-> linkClk [*4];
    endproperty
    a_hold_high: assert property (p_hold_high)
        else $error("link clock not held high after last pulse");

    property p_clear_idle;
        !clearN |-> linkClk && loadStrobeN;
    endproperty
    a_clear_idle: assert property (p_clear_idle)
        else $error("link active during clear");

    property p_por_len;
        $rose(clearN) |-> porCnt >= POR_CYCLES - 1 && porCnt <= POR_CYCLES + 1;
    endproperty
    a_por_len: assert property (p_por_len)
        else $error("clear length wrong");

    property p_clear_once;
        clearN |=> clearN;
    endproperty
    a_clear_once: assert property (p_clear_once)
        else $error("clear asserted again after power-on");

    property p_data_stable;
        $changed(serialDataIn) |-> linkClk;
    endproperty
    a_data_stable: assert property (p_data_stable)
        else $error("data changed while link clock low");

    property p_sel_onehot;
        $countones(~chipSelN) <= 1 || chipSelN == '0;
    endproperty
    a_sel_onehot: assert property (p_sel_onehot)
        else $error("select pattern neither single nor all");

    property p_sel_settled;
        $changed(chipSelN) |-> linkClk && loadStrobeN;
    endproperty
    a_sel_settled: assert property (p_sel_settled)
        else $error("select changed during a pulse or strobe");
endmodule

/* verification/test_two_wire_serial_dac_loader.sv */
// testbench of the loader: controller end and converter end joined
// assumes the design files and the link checker are compiled first
`timescale 1ns/1ps
`include "tws_consts.svh"
module test_two_wire_serial_dac_loader;
    localparam int POR = 10;
    logic             clock;
    logic             rst_n;
    logic             wordValid;
    logic             wordReady;
    logic [11:0]      wordData;
    logic [0:0]       sel;
    logic             isolatedMode;
    logic             busy;
    logic [1:0][11:0] outCode;
    logic [1:0]       loadDone;
    int               nFail;
    int               samplesChecked;
    int               doneCnt [2];
    int               rises;
    int               wireRises;
    int               base;
    int               i;
    logic [11:0]      shiftMon;
    logic [11:0]      wireWord;
    logic             lcPrev;
    logic             lsPrev;
    logic             fullSeen;

    // ------------------------------------------------------------------------
    // both ends and the checker
    // ------------------------------------------------------------------------
    tws_link_if #(.NUM_CONV(2)) u_tws_link_if ();
    tws_controller_end #(.POR_CYCLES(POR)) u_tws_controller_end (
        .clock(clock), .rst_n(rst_n), .wordValid(wordValid), .wordReady(wordReady),
        .wordData(wordData), .limitConverterSelect(sel), .isolatedMode(isolatedMode),
        .link(u_tws_link_if), .busy(busy));
    tws_converter_end #(.NUM_CONV(2)) u_tws_converter_end (
        .clock(clock), .rst_n(rst_n), .link(u_tws_link_if), .outCode(outCode),
        .loadDone(loadDone));
    tws_link_sva #(.NUM_CONV(2), .POR_CYCLES(POR)) u_tws_link_sva (
        .clock(clock), .rst_n(rst_n), .linkClk(u_tws_link_if.linkClk),
        .serialDataIn(u_tws_link_if.serialDataIn), .loadStrobeN(u_tws_link_if.loadStrobeN),
        .clearN(u_tws_link_if.clearN), .chipSelN(u_tws_link_if.chipSelN));

    // ------------------------------------------------------------------------
    // clock and wire monitor
    // ------------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // captures bits at link falls and counts link rises up to each strobe
    always @(posedge clock) begin
        if (loadDone[0] === 1'b1) doneCnt[0]++;
        if (loadDone[1] === 1'b1) doneCnt[1]++;
        if (lcPrev && !u_tws_link_if.linkClk && u_tws_link_if.loadStrobeN)
            shiftMon = {shiftMon[10:0], u_tws_link_if.serialDataIn};
        if (!lcPrev && u_tws_link_if.linkClk) rises++;
        if (lsPrev && !u_tws_link_if.loadStrobeN) begin
            wireWord = shiftMon;
            wireRises = rises;
        end
        if ((!lsPrev && u_tws_link_if.loadStrobeN) || !rst_n) rises = 0;
        lcPrev = u_tws_link_if.linkClk;
        lsPrev = u_tws_link_if.loadStrobeN;
    end

    // ------------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nFail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic giveVerdict();
        $display("checks=%0d mismatches=%0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // steps to just after a later rising edge
    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    // offers one word and holds it until taken; valid stays up afterwards
    task automatic pushWord(input logic [11:0] d, input logic s);
        int k;
        wordValid = 1'b1;
        wordData = d;
        sel = s;
        for (k = 0; k < 3000 && wordReady !== 1'b1; k++) begin
            fullSeen = 1'b1;
            cycles(1);
        end
        if (wordReady !== 1'b1) begin
            nFail++;
            giveVerdict();
        end
        cycles(1);
    endtask

    // waits until the controller has drained every word
    task automatic waitIdle();
        int k;
        wordValid = 1'b0;
        for (k = 0; k < 3000 && busy !== 1'b0; k++) cycles(1);
        if (busy !== 1'b0) begin
            nFail++;
            giveVerdict();
        end
        cycles(2);
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        wordValid = 1'b0;
        wordData = 12'h000;
        sel = 1'b0;
        isolatedMode = 1'b0;
        nFail = 0;
        samplesChecked = 0;
        doneCnt = '{0, 0};
        rises = 0;
        lcPrev = 1'b1;
        lsPrev = 1'b1;
        fullSeen = 1'b0;
        cycles(6);
        rst_n = 1'b1;
        // word offered while the shared clear still holds
        check({u_tws_link_if.clearN, u_tws_link_if.linkClk}, 2'b01);
        check(outCode[0], `TWS_ZERO_SCALE);
        pushWord(12'ha5c, 1'b0);
        check(outCode[1], `TWS_ZERO_SCALE);
        waitIdle();
        check(outCode[0], 12'ha5c);
        check(outCode[1], `TWS_ZERO_SCALE);
        check(wireWord, 12'ha5c);
        check(16'(wireRises), 16'h000c);
        check(16'(doneCnt[0]), 16'h0001);
        check(u_tws_converter_end.s_q.shiftReg, 12'ha5c);
        $display("test 1 done: load during clear");
        // back-to-back words to different converters, extreme codes
        pushWord(12'hfff, 1'b1);
        pushWord(12'h001, 1'b0);
        waitIdle();
        check(outCode[1], 12'hfff);
        check(outCode[0], 12'h001);
        check(wireWord, 12'h001);
        $display("test 2 done: back to back");
        // fill the buffer until it refuses, then drain it
        base = doneCnt[1];
        fullSeen = 1'b0;
        for (i = 0; i < 10; i++) pushWord(12'h100 + 12'(i), 1'b1);
        check(fullSeen, 1'b1);
        waitIdle();
        check(16'(doneCnt[1] - base), 16'h000a);
        check(outCode[1], 12'h109);
        check(outCode[0], 12'h001);
        $display("test 3 done: buffer full and drained");
        // isolated mode loads every converter
        isolatedMode = 1'b1;
        cycles(2);
        check(u_tws_link_if.chipSelN, 2'b00);
        pushWord(12'h7a3, 1'b1);
        waitIdle();
        check(outCode[0], 12'h7a3);
        check(outCode[1], 12'h7a3);
        isolatedMode = 1'b0;
        $display("test 4 done: isolated mode");
        // reset in the middle of a word, then a clean load
        pushWord(12'h333, 1'b0);
        wordValid = 1'b0;
        cycles(40);
        rst_n = 1'b0;
        #1;
        check(outCode[0], `TWS_ZERO_SCALE);
        check(outCode[1], `TWS_ZERO_SCALE);
        cycles(2);
        rst_n = 1'b1;
        pushWord(12'hc5a, 1'b0);
        waitIdle();
        check(outCode[0], 12'hc5a);
        check(outCode[1], `TWS_ZERO_SCALE);
        check(16'(wireRises), 16'h000c);
        $display("test 5 done: reset mid-word");
        giveVerdict();
    end
endmodule
